/* include/sacc_pkg.sv */
// Behaviour
// (R1) Writing start bit launches conversion; reads one while busy; single mode clears it.
// (R2) Channel change during conversion applies only after the running conversion ends.
// (R3) Result ready flag sets when a single sample or whole accumulation finishes.
// (R4) Interrupt request only when its enable and the global enable are one.
// (R5) Result ready flag sets on completion even with interrupt disabled.
// (R6) With event start enabled, every incoming event triggers a conversion; here an edge during a running conversion starts no new one.
// (R7) Event input is edge sensitive; edge sets start bit, completion clears it.
// (R8) Free-running: first by start write, next begins right after each completion.
// (R9) Conversion clock derived from core clock by selectable prescale factor.
// (R10) Prescaler counts once enabled; its counter is held zero while disabled; here counting also waits for a started conversion.
// (R11) After a trigger the conversion begins on next conversion clock rising edge.
// (R12) Prescaler held reset with no conversion; fixed delay factor/2 plus 2.
// (R13) Debug halt freezes the converter unless debug run enable is one.
// (R14) Results are 10-bit unsigned codes from 0 to 0x3ff.
// (R15) After reset the reference select chooses the internal reference.
// (R16) Software configures all fields first and sets the enable bit last.
// (R17) A normal conversion lasts 13 conversion clock cycles.
// (R18) Input is sampled and held 2 conversion clock cycles after start.
// (R19) Flag clears on result register read or on writing one to it.
// (R20) Channel and reference shadow frozen during conversion, tracks in last cycle.
// (R21) Start write or event during a conversion neither restarts nor aborts it.
package sacc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CONFIG  = 8'h04;
    localparam logic [7:0] OFS_EVCTRL  = 8'h08;
    localparam logic [7:0] OFS_COMMAND = 8'h0c;
    localparam logic [7:0] OFS_INTCTRL = 8'h10;
    localparam logic [7:0] OFS_FLAGS   = 8'h14;
    localparam logic [7:0] OFS_RESULT  = 8'h18;
    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FREE_RUN_ENABLE_BIT = 1;
    localparam int CTRL_RES8_BIT    = 2;
    localparam int CTRL_SAMP_LSB    = 4;
    localparam int CTRL_DEBUG_RUN_ENABLE_BIT  = 7;
    // Configuration register fields
    localparam int CFG_CLOCK_PRESCALE_SELECT_LSB = 0;
    localparam int CFG_REF_LSB   = 4;
    localparam int CFG_CHAN_LSB  = 8;
    // Field widths
    localparam int CLOCK_PRESCALE_SELECT_W = 3;
    localparam int REF_W   = 2;
    localparam int CHAN_W  = 5;
    localparam int SAMP_W  = 3;
    localparam int CODE_W  = 10;
    localparam int ACC_W   = 16;
    localparam int MAX_SAMP_SEL = 6;
    // Reset values; reference code zero is the internal reference
    localparam logic [REF_W-1:0]   REF_RESET   = 2'h0;
    localparam logic [CHAN_W-1:0]  CHAN_RESET  = 5'h00;
    localparam logic [CLOCK_PRESCALE_SELECT_W-1:0] CLOCK_PRESCALE_SELECT_RESET = 3'h0;
    // Conversion timing in conversion clock cycles
    localparam logic [3:0] STEP_LAST = 4'hc;
    localparam logic [3:0] STEP_HOLD = 4'h2;
    localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;
    // Conversion sequencer states
    typedef enum logic [0:0] {
        SACC_IDLE = 1'b0,
        SACC_CONV = 1'b1
    } sacc_state_e;
endpackage

/* rtl/sacc_top.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
module sacc_top #(
    parameter int CLOCK_PRESCALE_SELECT_STAGES = 8
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        EVENT_IN,
    input  wire logic        DEBUG_HALT,
    input  wire logic        GLOBAL_IE,
    input  wire logic        COMP_IN,
    output logic      [9:0]  SAR_CODE,
    output logic             SAMPLE_HOLD,
    output logic      [4:0]  CHANNEL_SEL,
    output logic      [1:0]  REF_SEL,
    output logic             ADC_POWER_EN,
    output logic             IRQ
);
    // Prescaler counter must hold the largest factor
    if (CLOCK_PRESCALE_SELECT_STAGES < 8) begin : g_clock_prescale_select_chk
        $error("CLOCK_PRESCALE_SELECT_STAGES must be at least 8");
    end

    // Software state
    logic                         enable_q, free_run_q, res8_q, dbg_run_q;
    logic [sacc_pkg::SAMP_W-1:0]  samp_sel_q;
    logic [sacc_pkg::CLOCK_PRESCALE_SELECT_W-1:0] clock_prescale_select_q;
    logic [sacc_pkg::REF_W-1:0]   ref_q, ref_sh_q;
    logic [sacc_pkg::CHAN_W-1:0]  chan_q, chan_sh_q;
    logic                         ev_en_q, ie_q, start_q, flag_q, ev_prev_q;
    // Bus state
    logic                         wr_q;
    logic [7:0]                   waddr_q;
    logic [31:0]                  rdata_q;
    // Conversion state
    sacc_pkg::sacc_state_e        state_q;
    logic [3:0]                   step_q;
    logic [5:0]                   samp_q;
    logic [sacc_pkg::CODE_W-1:0]  dac_q;
    logic [sacc_pkg::ACC_W-1:0]   acc_q, result_q;
    logic [CLOCK_PRESCALE_SELECT_STAGES-1:0]      cnt_q;
    logic                         sh_q, irq_q, run_q;

    // Limit of the prescaler counter for a given select
    function automatic logic [CLOCK_PRESCALE_SELECT_STAGES-1:0] clock_prescale_select_top(
        input logic [sacc_pkg::CLOCK_PRESCALE_SELECT_W-1:0] sel);
        clock_prescale_select_top = CLOCK_PRESCALE_SELECT_STAGES'((2 << sel) - 1);
    endfunction

    // Prescaler count at which the conversion clock rises
    function automatic logic [CLOCK_PRESCALE_SELECT_STAGES-1:0] clock_prescale_select_half(
        input logic [sacc_pkg::CLOCK_PRESCALE_SELECT_W-1:0] sel);
        clock_prescale_select_half = CLOCK_PRESCALE_SELECT_STAGES'(1 << sel);
    endfunction

    // Index of the last sample of an accumulation
    function automatic logic [5:0] samp_last(
        input logic [sacc_pkg::SAMP_W-1:0] sel);
        logic [sacc_pkg::SAMP_W-1:0] s;
        s = (sel > 3'(sacc_pkg::MAX_SAMP_SEL)) ?
            3'(sacc_pkg::MAX_SAMP_SEL) : sel;
        samp_last = 6'((1 << s) - 1);
    endfunction

    // Bus decode
    logic addr_ph, wr_cmd, rd_result, ev_edge, halt, tick, active;
    logic done, last_samp, set_start, wr_flag_clr;
    logic [sacc_pkg::CODE_W-1:0] final_code, code_out;
    logic [sacc_pkg::ACC_W-1:0]  acc_sum;
    assign addr_ph   = HSEL && HREADY && HTRANS[1];
    assign rd_result = addr_ph && !HWRITE &&
                       (HADDR[7:0] == sacc_pkg::OFS_RESULT);
    assign wr_cmd    = wr_q && (waddr_q == sacc_pkg::OFS_COMMAND) && HWDATA[0];
    assign wr_flag_clr = wr_q && (waddr_q == sacc_pkg::OFS_FLAGS) && HWDATA[0];
    // (R6) (R7) Edge detect on event
    assign ev_edge   = EVENT_IN && !ev_prev_q && ev_en_q;
    // (R13) Debug halt gating
    assign halt      = DEBUG_HALT && !dbg_run_q;
    // (R11) (R12) Conversion clock rises at half the prescale count
    assign tick      = start_q && run_q && !halt &&
                       (cnt_q == clock_prescale_select_half(clock_prescale_select_q));
    assign active    = (state_q == sacc_pkg::SACC_CONV);
    assign last_samp = (samp_q == samp_last(samp_sel_q));
    assign done      = tick && active && (step_q == sacc_pkg::STEP_LAST) &&
                       last_samp;
    assign set_start = wr_cmd || ev_edge;
    // (R14) Unsigned code, reduced in low resolution mode
    assign final_code = {dac_q[sacc_pkg::CODE_W-1:1], COMP_IN};
    assign code_out   = res8_q ? (final_code >> 2) : final_code;
    assign acc_sum    = (samp_q == 6'h00) ? sacc_pkg::ACC_W'(code_out) :
                        acc_q + sacc_pkg::ACC_W'(code_out);

    // Address phase capture; zero wait state slave
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            wr_q    <= addr_ph && HWRITE;
            waddr_q <= HADDR[7:0];
        end
    end

    // Read data mux registered in the address phase
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ph && !HWRITE) begin
            unique case (HADDR[7:0])
                sacc_pkg::OFS_CTRL:    rdata_q <= {24'h000000, dbg_run_q,
                                           samp_sel_q, 1'b0, res8_q,
                                           free_run_q, enable_q};
                sacc_pkg::OFS_CONFIG:  rdata_q <= {19'h00000, chan_q,
                                           2'h0, ref_q, 1'b0, clock_prescale_select_q};
                sacc_pkg::OFS_EVCTRL:  rdata_q <= {31'h0, ev_en_q};
                sacc_pkg::OFS_COMMAND: rdata_q <= {31'h0, start_q};
                sacc_pkg::OFS_INTCTRL: rdata_q <= {31'h0, ie_q};
                sacc_pkg::OFS_FLAGS:   rdata_q <= {31'h0, flag_q};
                sacc_pkg::OFS_RESULT:  rdata_q <= {16'h0000, result_q};
                default:               rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers; channel and reference reset to internal
    // (R15) Internal reference default
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            enable_q   <= 1'b0;
            free_run_q <= 1'b0;
            res8_q     <= 1'b0;
            dbg_run_q  <= 1'b0;
            samp_sel_q <= 3'h0;
            clock_prescale_select_q    <= sacc_pkg::CLOCK_PRESCALE_SELECT_RESET;
            ref_q      <= sacc_pkg::REF_RESET;
            chan_q     <= sacc_pkg::CHAN_RESET;
            ev_en_q    <= 1'b0;
            ie_q       <= 1'b0;
        end else if (wr_q) begin
            unique case (waddr_q)
                sacc_pkg::OFS_CTRL: begin
                    enable_q   <= HWDATA[sacc_pkg::CTRL_ENABLE_BIT];
                    free_run_q <= HWDATA[sacc_pkg::CTRL_FREE_RUN_ENABLE_BIT];
                    res8_q     <= HWDATA[sacc_pkg::CTRL_RES8_BIT];
                    dbg_run_q  <= HWDATA[sacc_pkg::CTRL_DEBUG_RUN_ENABLE_BIT];
                    samp_sel_q <= HWDATA[sacc_pkg::CTRL_SAMP_LSB +: 3];
                end
                sacc_pkg::OFS_CONFIG: begin
                    clock_prescale_select_q <= HWDATA[sacc_pkg::CFG_CLOCK_PRESCALE_SELECT_LSB +: 3];
                    ref_q   <= HWDATA[sacc_pkg::CFG_REF_LSB +: 2];
                    chan_q  <= HWDATA[sacc_pkg::CFG_CHAN_LSB +: 5];
                end
                sacc_pkg::OFS_EVCTRL:  ev_en_q <= HWDATA[0];
                sacc_pkg::OFS_INTCTRL: ie_q    <= HWDATA[0];
                default: ;
            endcase
        end
    end

    // Event input history
    always_ff @(posedge CORE_CLK) begin
        if (RST) ev_prev_q <= 1'b0;
        else     ev_prev_q <= EVENT_IN;
    end

    // (R1) (R7) Start bit: set wins over hardware clear
    always_ff @(posedge CORE_CLK) begin
        if (RST || !enable_q) begin
            start_q <= 1'b0;
        end else if (set_start) begin
            start_q <= 1'b1;
        end else if (done && !free_run_q) begin
            start_q <= 1'b0;
        end
    end

    // (R12) Start delay: run flag lags start bit by one cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST || !enable_q) run_q <= 1'b0;
        else                  run_q <= start_q;
    end

    // (R9) (R10) (R12) Prescaler held at zero without enable or start
    always_ff @(posedge CORE_CLK) begin
        if (RST || !enable_q || !start_q || !run_q) begin
            cnt_q <= '0;
        end else if (!halt) begin
            cnt_q <= (cnt_q == clock_prescale_select_top(clock_prescale_select_q)) ? '0 : cnt_q + 1'b1;
        end
    end

    // (R2) (R20) Shadow tracks while idle and in the last conversion step
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            chan_sh_q <= sacc_pkg::CHAN_RESET;
            ref_sh_q  <= sacc_pkg::REF_RESET;
        end else if (!active || step_q == sacc_pkg::STEP_LAST) begin
            chan_sh_q <= chan_q;
            ref_sh_q  <= ref_q;
        end
    end

    // Conversion sequencer, one step per conversion clock
    always_ff @(posedge CORE_CLK) begin
        if (RST || !enable_q) begin
            state_q  <= sacc_pkg::SACC_IDLE;
            step_q   <= 4'h0;
            samp_q   <= 6'h00;
            dac_q    <= '0;
            acc_q    <= '0;
            result_q <= '0;
        end else if (tick) begin
            unique case (state_q)
                // (R21) Starts only from idle
                sacc_pkg::SACC_IDLE: begin
                    state_q <= sacc_pkg::SACC_CONV;
                    step_q  <= 4'h0;
                    samp_q  <= 6'h00;
                end
                sacc_pkg::SACC_CONV: begin
                    // (R17) Thirteen clock conversion
                    if (step_q == sacc_pkg::STEP_LAST) begin
                        step_q <= 4'h0;
                        dac_q  <= '0;
                        acc_q  <= acc_sum;
                        // (R3) (R8) Sequence end, free run restarts
                        if (last_samp) begin
                            samp_q   <= 6'h00;
                            result_q <= acc_sum;
                            if (!free_run_q) state_q <= sacc_pkg::SACC_IDLE;
                        end else begin
                            samp_q <= samp_q + 6'h01;
                        end
                    end else begin
                        step_q <= step_q + 4'h1;
                        // Resolve previous trial bit
                        if (step_q > sacc_pkg::STEP_HOLD && !COMP_IN)
                            dac_q[4'(sacc_pkg::STEP_LAST - step_q)] <= 1'b0;
                        // Place next trial bit
                        if (step_q >= sacc_pkg::STEP_HOLD)
                            dac_q[4'(sacc_pkg::STEP_LAST - 4'h1 - step_q)]
                                <= 1'b1;
                    end
                end
            endcase
        end
    end

    // (R18) Sample and hold strobe two clocks after start
    always_ff @(posedge CORE_CLK) begin
        if (RST) sh_q <= 1'b0;
        else     sh_q <= tick && active &&
                         (step_q == sacc_pkg::STEP_HOLD - 4'h1);
    end

    // (R3) (R5) (R19) Flag: completion wins over clear
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else if (done) begin
            flag_q <= 1'b1;
        end else if (rd_result || wr_flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // (R4) Interrupt gating
    always_ff @(posedge CORE_CLK) begin
        if (RST) irq_q <= 1'b0;
        else     irq_q <= flag_q && ie_q && GLOBAL_IE;
    end

    // Bus response flops, always ready and okay
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Outputs straight from flops
    assign HRDATA       = rdata_q;
    assign SAR_CODE     = dac_q;
    assign SAMPLE_HOLD  = sh_q;
    assign CHANNEL_SEL  = chan_sh_q;
    assign REF_SEL      = ref_sh_q;
    assign ADC_POWER_EN = enable_q;
    assign IRQ          = irq_q;

    // Checks
    a_busy_start: assert property (@(posedge CORE_CLK) disable iff (RST) // R1
        active |-> start_q) else $error("busy without start bit");
    a_single_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // R1
        done && !free_run_q && !set_start |=> !start_q && !active)
        else $error("single conversion left start bit set");
    a_flag_set: assert property (@(posedge CORE_CLK) disable iff (RST) // R3
        done |=> flag_q) else $error("flag not set on completion");
    a_irq_gate: assert property (@(posedge CORE_CLK) disable iff (RST) // R4
        IRQ == $past(flag_q && ie_q && GLOBAL_IE))
        else $error("interrupt not gated by enables");
    a_event_start: assert property (@(posedge CORE_CLK) disable iff (RST) // R7
        ev_edge && enable_q |=> start_q) else $error("event lost");
    a_free_run: assert property (@(posedge CORE_CLK) disable iff (RST) // R8
        done && free_run_q && enable_q |=> active && step_q == 4'h0)
        else $error("free run did not restart");
    a_clock_prescale_select_hold: assert property (@(posedge CORE_CLK) disable iff (RST) // R12
        !start_q |=> cnt_q == '0) else $error("prescaler not held");
    a_shadow_lock: assert property (@(posedge CORE_CLK) disable iff (RST) // R20
        active && step_q != sacc_pkg::STEP_LAST ##1 active
        |-> $stable(chan_sh_q) && $stable(ref_sh_q))
        else $error("shadow changed mid conversion");
    a_no_restart: assert property (@(posedge CORE_CLK) disable iff (RST) // R21
        active && set_start && !tick |=> $stable(step_q) && active)
        else $error("start disturbed running conversion");
    a_step_bound: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
        step_q <= sacc_pkg::STEP_LAST) else $error("step overrun");
    a_debug_halt: assert property (@(posedge CORE_CLK) disable iff (RST) // R13
        halt && enable_q && start_q |=> $stable(cnt_q))
        else $error("prescaler ran during halt");
    a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // R19
        (rd_result || wr_flag_clr) && !done |=> !flag_q)
        else $error("flag not cleared by software");
    a_hold_pulse: assert property (@(posedge CORE_CLK) disable iff (RST) // R18
        sh_q && enable_q |-> active && step_q == sacc_pkg::STEP_HOLD)
        else $error("sample strobe off its step");

    c_single: cover property (@(posedge CORE_CLK) done && !free_run_q);
    c_free: cover property (@(posedge CORE_CLK) done && free_run_q);
    c_event: cover property (@(posedge CORE_CLK) ev_edge && !start_q);
    c_hold: cover property (@(posedge CORE_CLK) sh_q);
    c_halt: cover property (@(posedge CORE_CLK) halt && start_q);
endmodule // sacc_top

/* testbench/sacc_afe_model.sv */
// Analog side of the converter: channel levels, track and hold, comparator
module sacc_afe_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sample_hold,
    input  wire logic [4:0] channel_sel,
    input  wire logic [9:0] sar_code,
    output logic            comp_in
);
    logic [9:0] held_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            held_q <= 10'h0;
        end else if (sample_hold) begin
            held_q <= (channel_sel == 5'h1f) ? 10'h3ff
                                             : {5'h0, channel_sel} * 10'h21;
        end
    end

    assign comp_in = (held_q >= sar_code);
endmodule // sacc_afe_model

/* testbench/tb_sar_adc_conversion_control.sv */
module tb_sar_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0]  ch;
        logic [2:0]  clock_prescale_select;
        logic [2:0]  samp;
        logic [15:0] res;
    } sacc_row_s;
    // Channel, prescale, sample select (2 to that power samples, select 7 taken as 6) and the sum they should give
    localparam sacc_row_s ROWS [6] = '{
        '{5'h00, 3'h0, 3'h0, 16'h0000}, '{5'h1f, 3'h1, 3'h0, 16'h03ff},
        '{5'h05, 3'h0, 3'h2, 16'h0294}, '{5'h1f, 3'h0, 3'h6, 16'hffc0},
        '{5'h01, 3'h0, 3'h7, 16'h0840}, '{5'h02, 3'h2, 3'h1, 16'h0084}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b1;
    logic        hwrite = 1'b0;
    logic        evt = 1'b0;
    logic        dbg = 1'b0;
    logic        gie = 1'b0;
    logic        irq_d = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire  [9:0]  sar_code;
    wire  [4:0]  chan;
    wire  [1:0]  ref_sel;
    wire         hready, hresp, comp, sh, pwr, irq;
    int          num_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          sh_n = 0;
    int          sh_t = 0;
    int          irq_n = 0;
    int          irq_t = 0;

    always #20 clk = ~clk;

    // Device with the analog model on its far side
    sacc_top #(.CLOCK_PRESCALE_SELECT_STAGES(8)) dut (
        .CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .EVENT_IN(evt), .DEBUG_HALT(dbg), .GLOBAL_IE(gie), .COMP_IN(comp),
        .SAR_CODE(sar_code), .SAMPLE_HOLD(sh), .CHANNEL_SEL(chan),
        .REF_SEL(ref_sel), .ADC_POWER_EN(pwr), .IRQ(irq));
    sacc_afe_model afe (.clk(clk), .rst(rst), .sample_hold(sh),
        .channel_sel(chan), .sar_code(sar_code), .comp_in(comp));

    // Count hold pulses and interrupt rises with their cycle stamps
    always @(posedge clk) begin
        cyc <= cyc + 1;
        irq_d <= irq;
        if (sh === 1'b1) begin
            sh_n <= sh_n + 1;
            sh_t <= cyc;
        end
        if (irq === 1'b1 && irq_d !== 1'b1) begin
            irq_n <= irq_n + 1;
            irq_t <= cyc;
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single transfer; read data taken at the data phase edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        if (!w) begin
            @(posedge clk);
        end
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start;
        wr(sacc_pkg::OFS_COMMAND, 32'h1);
    endtask

    // Poll the flag register under a bound
    task automatic wait_flag;
        logic [31:0] q = 32'h0;
        int          n = 0;
        while (q[0] !== 1'b1 && n < 3000) begin
            xfer(1'b0, sacc_pkg::OFS_FLAGS, 32'h0, q);
            n++;
        end
        chk("result ready", 32'h1, q);
    endtask

    task automatic setup(input logic [31:0] ctrl, input logic [31:0] cfg);
        wr(sacc_pkg::OFS_CTRL, ctrl & ~32'h1);
        wr(sacc_pkg::OFS_CONFIG, cfg);
        wr(sacc_pkg::OFS_CTRL, ctrl | 32'h1);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop();
    end

    // Main sequence
    initial begin
        int s0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("ctrl", sacc_pkg::OFS_CTRL, 32'h0);
        rdc("config", sacc_pkg::OFS_CONFIG,
            32'(sacc_pkg::REF_RESET) << sacc_pkg::CFG_REF_LSB);
        rdc("command", sacc_pkg::OFS_COMMAND, 32'h0);
        rdc("flags", sacc_pkg::OFS_FLAGS, 32'h0);
        rdc("unmapped", 8'h1c, 32'h0);
        @(negedge clk);
        chk("ref pin", 32'(sacc_pkg::REF_RESET), 32'(ref_sel));
        chk("response", 32'h0, 32'(hresp));
        @(posedge clk);
        $display("test reset done");
        foreach (ROWS[i]) begin
            setup({25'h0, ROWS[i].samp, 4'h0},
                  {19'h0, ROWS[i].ch, 5'h0, ROWS[i].clock_prescale_select});
            start();
            wait_flag();
            rdc("sum", sacc_pkg::OFS_RESULT, {16'h0, ROWS[i].res});
            rdc("flag read", sacc_pkg::OFS_FLAGS, 32'h0);
            rdc("start done", sacc_pkg::OFS_COMMAND, 32'h0);
            $display("test row %0d done", i);
        end
        chk("irq off", 32'h0, irq_n);
        setup(32'h0, 32'h0500);
        s0 = sh_n;
        start();
        rdc("busy", sacc_pkg::OFS_COMMAND, 32'h1);
        chk("power on", 32'h1, 32'(pwr));
        idle(6);
        start();
        wait_flag();
        rdc("result", sacc_pkg::OFS_RESULT, 32'h00a5);
        idle(60);
        chk("samples", s0 + 1, sh_n);
        rdc("no rerun", sacc_pkg::OFS_FLAGS, 32'h0);
        $display("test restart done");
        setup(32'h4, 32'h0500);
        start();
        wait_flag();
        rdc("low res", sacc_pkg::OFS_RESULT, 32'h0029);
        setup(32'h0, 32'h0503);
        start();
        idle(20);
        wr(sacc_pkg::OFS_CONFIG, 32'h1f13);
        @(negedge clk);
        chk("frozen channel", 32'h5, 32'(chan));
        chk("frozen ref", 32'h0, 32'(ref_sel));
        @(posedge clk);
        wait_flag();
        rdc("old channel", sacc_pkg::OFS_RESULT, 32'h00a5);
        start();
        wait_flag();
        rdc("new channel", sacc_pkg::OFS_RESULT, 32'h03ff);
        chk("new ref", 32'h1, 32'(ref_sel));
        $display("test channel done");
        setup(32'h2, 32'h0500);
        start();
        wait_flag();
        rdc("first run", sacc_pkg::OFS_RESULT, 32'h00a5);
        wait_flag();
        rdc("next run", sacc_pkg::OFS_RESULT, 32'h00a5);
        rdc("still busy", sacc_pkg::OFS_COMMAND, 32'h1);
        wr(sacc_pkg::OFS_CTRL, 32'h0);
        rdc("stopped", sacc_pkg::OFS_COMMAND, 32'h0);
        chk("power off", 32'h0, 32'(pwr));
        $display("test free run done");
        setup(32'h0, 32'h0500);
        wr(sacc_pkg::OFS_EVCTRL, 32'h1);
        for (int k = 0; k < 2; k++) begin
            s0 = sh_n;
            evt <= 1'b1;
            idle(4);
            rdc("event busy", sacc_pkg::OFS_COMMAND, 32'h1);
            wait_flag();
            idle(40);
            chk("one per edge", s0 + 1, sh_n);
            evt <= 1'b0;
            rdc("event result", sacc_pkg::OFS_RESULT, 32'h00a5);
        end
        wr(sacc_pkg::OFS_EVCTRL, 32'h0);
        s0 = sh_n;
        evt <= 1'b1;
        idle(60);
        evt <= 1'b0;
        chk("event off", s0, sh_n);
        $display("test event done");
        dbg <= 1'b1;
        s0 = sh_n;
        start();
        idle(100);
        chk("halted", s0, sh_n);
        dbg <= 1'b0;
        wait_flag();
        rdc("after halt", sacc_pkg::OFS_RESULT, 32'h00a5);
        setup(32'h80, 32'h0500);
        dbg <= 1'b1;
        start();
        wait_flag();
        dbg <= 1'b0;
        rdc("debug run", sacc_pkg::OFS_RESULT, 32'h00a5);
        $display("test debug done");
        wr(sacc_pkg::OFS_INTCTRL, 32'h1);
        start();
        wait_flag();
        idle(3);
        chk("masked", 32'h0, irq_n);
        gie <= 1'b1;
        idle(3);
        chk("raised", 32'h1, irq_n);
        wr(sacc_pkg::OFS_FLAGS, 32'h1);
        rdc("cleared", sacc_pkg::OFS_FLAGS, 32'h0);
        @(negedge clk);
        chk("irq low", 32'h0, 32'(irq));
        @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            wr(sacc_pkg::OFS_CONFIG, 32'h0500 | p);
            start();
            s0 = cyc;
            wait_flag();
            idle(2);
            chk("hold to irq", 11 * (2 << p) + 1, irq_t - sh_t);
            chk("start delay", (1 << p) + 3 + (4 << p), sh_t - s0);
            wr(sacc_pkg::OFS_FLAGS, 32'h1);
        end
        $display("test interrupt done");
        report_and_stop();
    end
endmodule // tb_sar_adc_conversion_control
